/* include/prot_pkg.sv */
// Shared constants and types of the output protection state controller
package prot_pkg;

	localparam int NUM_CH = 8;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// Times in milliseconds
	localparam int unsigned INIT_MS = 250;
	localparam int unsigned START_MAX_MS = 5000;
	localparam int unsigned HOLD_MIN_MS = 500;
	localparam int unsigned HOLD_MAX_MS = 20000;
	localparam int unsigned HOLD_MS = 1000;
	localparam int unsigned RST_PULSE_MS = 500;
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned FAST_BLINK_MS = 50;

	// Cycle counts derived from the times
	localparam int unsigned INIT_CYC = INIT_MS * CYC_PER_MS;
	localparam int unsigned START_MAX_CYC = START_MAX_MS * CYC_PER_MS;
	localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
	localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;
	localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
	localparam int unsigned FAST_BLINK_CYC = FAST_BLINK_MS * CYC_PER_MS;

	// Reset values
	localparam logic [NUM_CH-1:0] OUT_RST = 8'h00;
	localparam logic ALARM_RST = 1'b0;

	// Per-channel status
	typedef enum logic [2:0] {
		ST_INIT,
		ST_ON,
		ST_OVERCUR,
		ST_MANOFF,
		ST_TRIP_HOLD,
		ST_TRIP_RST,
		ST_FAULT
	} ch_state_t;

	// Start-up sequencer
	typedef enum logic [1:0] {
		SQ_INIT,
		SQ_START,
		SQ_WAIT,
		SQ_DONE
	} seq_state_t;

endpackage

/* design/output_protection_state_controller.sv */
// Channel protection, start-up sequencing, indicators and alarm contact
module output_protection_state_controller #(
	parameter int unsigned INIT_CYC = prot_pkg::INIT_CYC,
	parameter int unsigned START_MAX_CYC = prot_pkg::START_MAX_CYC,
	parameter int unsigned HOLD_CYC = prot_pkg::HOLD_CYC,
	parameter int unsigned RST_PULSE_CYC = prot_pkg::RST_PULSE_CYC,
	parameter int unsigned BLINK_CYC = prot_pkg::BLINK_CYC,
	parameter int unsigned FAST_BLINK_CYC = prot_pkg::FAST_BLINK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic limited_power_variant,
	input wire logic over_voltage,
	input wire logic [prot_pkg::NUM_CH-1:0] ch_overcurrent,
	input wire logic [prot_pkg::NUM_CH-1:0] ch_trip_curve,
	input wire logic [prot_pkg::NUM_CH-1:0] ch_load_ready,
	input wire logic [prot_pkg::NUM_CH-1:0] button_press,
	input wire logic [prot_pkg::NUM_CH-1:0] fuse_fail,
	input wire logic mem_error,
	input wire logic reset_line,
	input wire logic power_fail,
	input wire logic nv_blank,
	input prot_pkg::ch_state_t nv_rd_state [prot_pkg::NUM_CH],
	output logic [prot_pkg::NUM_CH-1:0] ch_out_en,
	output logic [prot_pkg::NUM_CH-1:0] led_green,
	output logic [prot_pkg::NUM_CH-1:0] led_red,
	output logic trip_alarm_contact,
	output logic nv_wr_en,
	output prot_pkg::ch_state_t nv_wr_state [prot_pkg::NUM_CH]
);
	import prot_pkg::*;

	ch_state_t ch_state_reg [NUM_CH];
	logic [31:0] hold_cnt_reg [NUM_CH];
	logic [NUM_CH-1:0] start_pulse;
	logic [NUM_CH-1:0] fault_now;
	seq_state_t seq_reg;
	logic [2:0] seq_idx_reg;
	logic [31:0] seq_cnt_reg;
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [31:0] rst_cnt_reg;
	logic reset_fire;
	logic ov_reg;
	logic [31:0] blink_cnt_reg;
	logic [31:0] fast_cnt_reg;
	logic blink_reg;
	logic fast_reg;
	logic pf_reg;
	logic [NUM_CH-1:0] out_en_next;
	logic alarm_next;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Overvoltage and reset input conditioning

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_reg <= 1'b0;
		end else begin
			ov_reg <= limited_power_variant & over_voltage;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= reset_line;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Count high cycles; one fire per pulse, so a held line acts once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_reg <= 32'h0;
		end else if (!rst_sync_reg) begin
			rst_cnt_reg <= 32'h0;
		end else if (rst_cnt_reg <= RST_PULSE_CYC) begin
			rst_cnt_reg <= rst_cnt_reg + 32'h1;
		end
	end

	assign reset_fire = rst_sync_reg && (rst_cnt_reg == RST_PULSE_CYC);

	a_reset_width: assert property (
		reset_fire |-> $past(rst_sync_reg) && rst_cnt_reg >= 32'd1)
		else $error("reset accepted without a long high level");

	////////////////////////////////////////////////////////////////////////
	// Blink dividers

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= 1'b0;
		end else if (blink_cnt_reg == BLINK_CYC - 1) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_cnt_reg <= 32'h0;
			fast_reg <= 1'b0;
		end else if (fast_cnt_reg == FAST_BLINK_CYC - 1) begin
			fast_cnt_reg <= 32'h0;
			fast_reg <= ~fast_reg;
		end else begin
			fast_cnt_reg <= fast_cnt_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start-up sequencer

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg <= SQ_INIT;
			seq_idx_reg <= 3'h0;
			seq_cnt_reg <= 32'h0;
		end else begin
			unique case (seq_reg)
				SQ_INIT: begin
					if (seq_cnt_reg == INIT_CYC - 1) begin
						seq_reg <= SQ_START;
						seq_cnt_reg <= 32'h0;
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 32'h1;
					end
				end
				SQ_START: begin
					seq_reg <= SQ_WAIT;
					seq_cnt_reg <= 32'h0;
				end
				SQ_WAIT: begin
					// Channels not restored to on need no settling time
					if (ch_load_ready[seq_idx_reg] ||
						ch_state_reg[seq_idx_reg] != ST_ON ||
						seq_cnt_reg == START_MAX_CYC - 1) begin
						seq_cnt_reg <= 32'h0;
						if (seq_idx_reg == 3'(NUM_CH - 1)) begin
							seq_reg <= SQ_DONE;
						end else begin
							seq_idx_reg <= seq_idx_reg + 3'h1;
							seq_reg <= SQ_START;
						end
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 32'h1;
					end
				end
				SQ_DONE: begin
					seq_cnt_reg <= 32'h0;
				end
			endcase
		end
	end

	a_init_first: assert property (
		seq_reg == SQ_INIT ##1 seq_reg == SQ_START
		|-> $past(seq_cnt_reg) == INIT_CYC - 1)
		else $error("first channel started before initialization ended");

	a_startup_force: assert property (
		seq_reg == SQ_WAIT && seq_cnt_reg == START_MAX_CYC - 1
		|=> seq_reg != SQ_WAIT)
		else $error("start-up delay not cut at its limit");

	////////////////////////////////////////////////////////////////////////
	// Channel state machines

	assign fault_now = fuse_fail | {NUM_CH{mem_error}};

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		ch_state_t restored;

		assign start_pulse[i] = (seq_reg == SQ_START) &&
			(seq_idx_reg == 3'(i));

		// Stored running states come back as on; blank memory is all on
		always_comb begin
			restored = ST_ON;
			if (!nv_blank) begin
				unique case (nv_rd_state[i])
					ST_MANOFF, ST_TRIP_HOLD, ST_TRIP_RST, ST_FAULT: begin
						restored = nv_rd_state[i];
					end
					default: begin
						restored = ST_ON;
					end
				endcase
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ch_state_reg[i] <= ST_INIT;
			end else if (ch_state_reg[i] == ST_INIT) begin
				if (start_pulse[i]) begin
					ch_state_reg[i] <= restored;
				end
			end else if (fault_now[i]) begin
				ch_state_reg[i] <= ST_FAULT;
			end else if (!ov_reg) begin
				// Overvoltage freezes every state but fault entry and the start out of init, so without a fault it returns intact
				unique case (ch_state_reg[i])
					ST_ON: begin
						if (button_press[i]) begin
							ch_state_reg[i] <= ST_MANOFF;
						end else if (ch_overcurrent[i]) begin
							ch_state_reg[i] <= ST_OVERCUR;
						end
					end
					ST_OVERCUR: begin
						if (button_press[i]) begin
							ch_state_reg[i] <= ST_MANOFF;
						end else if (ch_trip_curve[i]) begin
							ch_state_reg[i] <= ST_TRIP_HOLD;
						end else if (!ch_overcurrent[i]) begin
							ch_state_reg[i] <= ST_ON;
						end
					end
					ST_MANOFF: begin
						if (button_press[i]) begin
							ch_state_reg[i] <= ST_ON;
						end
					end
					ST_TRIP_HOLD: begin
						if (hold_cnt_reg[i] == HOLD_CYC - 1) begin
							ch_state_reg[i] <= ST_TRIP_RST;
						end
					end
					ST_TRIP_RST: begin
						if (button_press[i]) begin
							ch_state_reg[i] <= ST_MANOFF;
						end else if (reset_fire) begin
							ch_state_reg[i] <= ST_ON;
						end
					end
					ST_FAULT: begin
						ch_state_reg[i] <= ST_FAULT;
					end
					default: begin
						ch_state_reg[i] <= ST_FAULT;
					end
				endcase
			end
		end

		// Cool-down timer; restarts on every entry into the hold state
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				hold_cnt_reg[i] <= 32'h0;
			end else if (ch_state_reg[i] != ST_TRIP_HOLD) begin
				hold_cnt_reg[i] <= 32'h0;
			end else if (!ov_reg) begin
				hold_cnt_reg[i] <= hold_cnt_reg[i] + 32'h1;
			end
		end

		// Green and red together make yellow
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				led_green[i] <= 1'b0;
				led_red[i] <= 1'b0;
			end else if (ov_reg && ch_state_reg[i] != ST_INIT) begin
				led_green[i] <= 1'b0;
				led_red[i] <= fast_reg;
			end else begin
				unique case (ch_state_reg[i])
					ST_INIT: begin
						led_green[i] <= 1'b0;
						led_red[i] <= 1'b0;
					end
					ST_ON: begin
						led_green[i] <= 1'b1;
						led_red[i] <= 1'b0;
					end
					ST_OVERCUR: begin
						led_green[i] <= 1'b1;
						led_red[i] <= 1'b1;
					end
					ST_MANOFF: begin
						led_green[i] <= 1'b0;
						led_red[i] <= 1'b1;
					end
					ST_TRIP_HOLD: begin
						led_green[i] <= 1'b0;
						led_red[i] <= blink_reg;
					end
					ST_TRIP_RST: begin
						led_green[i] <= blink_reg;
						led_red[i] <= blink_reg;
					end
					default: begin
						led_green[i] <= 1'b0;
						led_red[i] <= fast_reg;
					end
				endcase
			end
		end

		assign out_en_next[i] = !ov_reg && !fault_now[i] &&
			(ch_state_reg[i] == ST_ON || ch_state_reg[i] == ST_OVERCUR);

		a_seq_order: assert property (
			start_pulse[i] |-> i == 0 || ch_state_reg[(i + NUM_CH - 1) % NUM_CH]
			!= ST_INIT)
			else $error("channel started ahead of its predecessor");

		a_hold_timing: assert property (
			ch_state_reg[i] == ST_TRIP_HOLD ##1 ch_state_reg[i] == ST_TRIP_RST
			|-> $past(hold_cnt_reg[i]) == HOLD_CYC - 1)
			else $error("trip cool-down ended at the wrong count");

		a_hold_locked: assert property (
			ch_state_reg[i] == ST_TRIP_HOLD && !fault_now[i]
			|=> ch_state_reg[i] inside {ST_TRIP_HOLD, ST_TRIP_RST}
			##1 !ch_out_en[i])
			else $error("non-resettable trip left by an input");

		a_reset_to_on: assert property (
			reset_fire && ch_state_reg[i] == ST_TRIP_RST && !ov_reg &&
			!button_press[i] && !fault_now[i]
			|=> ch_state_reg[i] == ST_ON ##1 ch_out_en[i])
			else $error("resettable trip not restored by reset");

		a_reset_others: assert property (
			reset_fire && ch_state_reg[i] == ST_MANOFF && !button_press[i] &&
			!fault_now[i] |=> ch_state_reg[i] == ST_MANOFF)
			else $error("reset changed a channel it must not touch");

		a_button_off: assert property (
			button_press[i] && ch_state_reg[i] == ST_ON && !ov_reg &&
			!fault_now[i] |=> ch_state_reg[i] == ST_MANOFF)
			else $error("button did not switch the channel off");

		a_fault_cut: assert property (
			fault_now[i] && ch_state_reg[i] != ST_INIT
			|=> ch_state_reg[i] == ST_FAULT ##1 !ch_out_en[i])
			else $error("fault did not disconnect the output");

		c_trip_cycle: cover property (
			ch_state_reg[i] == ST_TRIP_RST ##1 ch_state_reg[i] == ST_ON);
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, alarm contact and state saving

	always_comb begin
		alarm_next = !ov_reg && (seq_reg == SQ_DONE);
		for (int k = 0; k < NUM_CH; k++) begin
			if (ch_state_reg[k] != ST_ON && ch_state_reg[k] != ST_OVERCUR) begin
				alarm_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_out_en <= OUT_RST;
			trip_alarm_contact <= ALARM_RST;
		end else begin
			ch_out_en <= out_en_next;
			trip_alarm_contact <= alarm_next;
		end
	end

	// Snapshot every channel on the first cycle of power loss
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_reg <= 1'b0;
			nv_wr_en <= 1'b0;
			for (int k = 0; k < NUM_CH; k++) begin
				nv_wr_state[k] <= ST_ON;
			end
		end else begin
			pf_reg <= power_fail;
			nv_wr_en <= power_fail & ~pf_reg;
			if (power_fail & ~pf_reg) begin
				for (int k = 0; k < NUM_CH; k++) begin
					nv_wr_state[k] <= ch_state_reg[k];
				end
			end
		end
	end

	a_ov_all_off: assert property (
		ov_reg |=> ch_out_en == OUT_RST && !trip_alarm_contact)
		else $error("output left on during overvoltage");

	a_alarm_open: assert property (
		ch_state_reg[0] inside {ST_MANOFF, ST_TRIP_HOLD, ST_TRIP_RST, ST_FAULT}
		|=> !trip_alarm_contact)
		else $error("alarm contact closed with a channel tripped");

	c_seq_done: cover property (seq_reg == SQ_WAIT ##1 seq_reg == SQ_DONE);
	c_reset_fire: cover property (reset_fire);
	c_overvolt: cover property (ov_reg ##1 !ov_reg);

endmodule // output_protection_state_controller

/* testbench/far_side_model.sv */
// Model of the push buttons and the external reset line
module far_side_model (
	input wire logic clk,
	output logic [prot_pkg::NUM_CH-1:0] button_press,
	output logic reset_line
);
	timeunit 1ns;
	timeprecision 100ps;
	import prot_pkg::*;

	initial begin
		button_press = '0;
		reset_line = 1'b0;
	end

	// One push, one cycle wide
	task automatic press(input int ch);
		@(posedge clk);
		#1;
		button_press[ch] = 1'b1;
		@(posedge clk);
		#1;
		button_press = '0;
	endtask

	// Line held high for cyc cycles, then back to its low idle level
	task automatic pulse(input int cyc);
		@(posedge clk);
		#1;
		reset_line = 1'b1;
		repeat (cyc) @(posedge clk);
		#1;
		reset_line = 1'b0;
	endtask
endmodule // far_side_model

/* testbench/tb.sv */
// Self-checking testbench of the output protection state controller
`define CHK(a, b) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		errors++; \
		$display("[ERR] %0t got %h want %h", $time, (a), (b)); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import prot_pkg::*;

	localparam int INIT = 20;
	localparam int SMAX = 50;
	localparam int HOLD = 30;
	localparam int RPUL = 10;
	localparam int BL = 4;
	localparam int FB = 2;

	logic clk, rst_n, lpv, ov, mem_error, power_fail, nv_blank;
	logic [7:0] oc, curve, ready, fuse, out_en, g, r;
	logic [7:0] btn;
	logic rline, alarm, nv_wr_en;
	ch_state_t nv_rd [NUM_CH];
	ch_state_t nv_wr [NUM_CH];
	int errors, total_checks, seed, t, m, n;
	logic gh, gl, rh, rl;

	output_protection_state_controller #(.INIT_CYC(INIT),
		.START_MAX_CYC(SMAX), .HOLD_CYC(HOLD), .RST_PULSE_CYC(RPUL),
		.BLINK_CYC(BL), .FAST_BLINK_CYC(FB)) i_dut (
		.clk(clk), .rst_n(rst_n), .limited_power_variant(lpv),
		.over_voltage(ov), .ch_overcurrent(oc), .ch_trip_curve(curve),
		.ch_load_ready(ready), .button_press(btn), .fuse_fail(fuse),
		.mem_error(mem_error), .reset_line(rline),
		.power_fail(power_fail), .nv_blank(nv_blank),
		.nv_rd_state(nv_rd), .ch_out_en(out_en), .led_green(g),
		.led_red(r), .trip_alarm_contact(alarm), .nv_wr_en(nv_wr_en),
		.nv_wr_state(nv_wr));

	far_side_model i_far (.clk(clk), .button_press(btn),
		.reset_line(rline));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	function automatic logic [7:0] bit_at(input int c);
		return 8'h01 << c;
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Records which levels channel c's indicator showed over n cycles
	task automatic watch(input int c, input int n);
		gh = 0;
		gl = 0;
		rh = 0;
		rl = 0;
		repeat (n) begin
			tick(1);
			if (g[c] === 1'b1) gh = 1; else gl = 1;
			if (r[c] === 1'b1) rh = 1; else rl = 1;
		end
	endtask

	task automatic startup(input logic [7:0] on_mask, input logic [7:0] slow);
		rst_n = 1'b0;
		tick(16);
		rst_n = 1'b1;
		repeat (INIT - 2) begin
			tick(1);
			`CHK(out_en | g | r, 8'h00)
		end
		for (int c = 0; c < NUM_CH; c++) begin
			t = 0;
			while (on_mask[c] && out_en[c] !== 1'b1 && t < SMAX + 9) begin
				tick(1);
				t++;
				if (on_mask == 8'hff)
					`CHK((out_en + 8'h01) & out_en, 8'h00)
			end
			if (c == 7 && slow[6])
				`CHK(t >= SMAX - 4 && t <= SMAX + 4, 1'b1)
			if (on_mask[c]) `CHK(out_en[c], 1'b1)
			if (!slow[c] && ready[c] !== 1'b1) begin
				tick(1 + ($random(seed) & 3));
				if (c < 7) `CHK(out_en[c + 1], 1'b0)
				ready[c] = 1'b1;
			end
		end
		tick(3);
	endtask

	initial begin
		#(25 * 6000);
		errors++;
		results();
	end

	initial begin
		seed = 4651;
		errors = 0;
		total_checks = 0;
		{rst_n, lpv, ov, mem_error, power_fail} = '0;
		nv_blank = 1'b1;
		{oc, curve, ready, fuse} = '0;
		foreach (nv_rd[k]) nv_rd[k] = ST_FAULT;
		`CHK(HOLD_MS >= HOLD_MIN_MS && HOLD_MS <= HOLD_MAX_MS, 1'b1)
		startup(8'hff, 8'h40);
		`CHK({alarm, g, r}, {1'b1, 8'hff, 8'h00})
		ov = 1'b1;
		tick(5);
		`CHK(out_en, 8'hff)
		ov = 1'b0;
		i_far.press(5);
		tick(3);
		`CHK({out_en, r[5], g[5], alarm}, {~bit_at(5), 3'b100})
		oc[2] = 1'b1;
		tick(3);
		`CHK({out_en[2], g[2], r[2]}, 3'b111)
		curve[2] = 1'b1;
		tick(1);
		curve[2] = 1'b0;
		tick(2);
		`CHK(out_en[2], 1'b0)
		watch(2, 2 * BL + 2);
		`CHK({gh, rh, rl}, 3'b011)
		i_far.press(2);
		oc[2] = 1'b0;
		tick(HOLD);
		watch(2, 2 * BL + 2);
		`CHK({gh, gl, rh, rl, out_en[2]}, 5'b11110)
		i_far.pulse(RPUL - 4);
		tick(4);
		`CHK(out_en[2], 1'b0)
		i_far.pulse(RPUL + 6);
		tick(3);
		`CHK(out_en, ~bit_at(5))
		lpv = 1'b1;
		ov = 1'b1;
		tick(3);
		`CHK({out_en, alarm}, 9'h000)
		watch(0, 2 * FB + 2);
		`CHK({gh, rh, rl}, 3'b011)
		i_far.press(3);
		ov = 1'b0;
		tick(3);
		`CHK(out_en, ~bit_at(5))
		i_far.press(5);
		fuse[4] = 1'b1;
		tick(3);
		fuse[4] = 1'b0;
		`CHK(out_en, ~bit_at(4))
		i_far.press(4);
		watch(4, 2 * FB + 2);
		`CHK({out_en[4], gh, rh, rl}, 4'b0011)
		power_fail = 1'b1;
		t = 0;
		while (nv_wr_en !== 1'b1 && t < 4) begin
			tick(1);
			t++;
		end
		`CHK({nv_wr_en, nv_wr[4], nv_wr[0]}, {1'b1, ST_FAULT, ST_ON})
		tick(1);
		`CHK(nv_wr_en, 1'b0)
		power_fail = 1'b0;
		mem_error = 1'b1;
		tick(3);
		`CHK(out_en, 8'h00)
		mem_error = 1'b0;
		nv_blank = 1'b0;
		m = $random(seed) & 7;
		foreach (nv_rd[k]) nv_rd[k] = ch_state_t'(($random(seed) & 1) + 1);
		nv_rd[m] = ST_MANOFF;
		// A stored resettable trip must come back as such, not as on
		n = (m + 4) & 7;
		nv_rd[n] = ST_TRIP_RST;
		ready = 8'hff;
		startup(~(bit_at(m) | bit_at(n)), 8'h00);
		`CHK({out_en, r[m], g[m], alarm}, {~(bit_at(m) | bit_at(n)), 3'b100})
		i_far.pulse(RPUL + 2);
		tick(4);
		`CHK(out_en, ~bit_at(m))
		results();
	end
endmodule // tb
